//--- common/cri_map.svh
/*
 * Constants of the interrupt entry unit and its peripheral end:
 * vectors, reset values, bit positions, register offsets, timing.
 * Assumes a 125 MHz system clock; included by bare name.
 */
`ifndef CRI_MAP_SVH
`define CRI_MAP_SVH

// program counter and vectors
`define CRI_PC_RESET       16'h0000
`define CRI_NMI_VECTOR     16'h0066
`define CRI_MODE1_VECTOR   16'h0038
`define CRI_REFRESH_RESET  8'h00
`define CRI_IDLE_BYTE      8'hFF

// acknowledge cycle length, least time rounded up
`define CRI_CLK_NS         8
`define CRI_IACK_NS        16
`define CRI_IACK_CYC       ((`CRI_IACK_NS + `CRI_CLK_NS - 1) / `CRI_CLK_NS)

// peripheral end register offsets (byte addresses)
`define CRI_OFS_CTRL       12'h000
`define CRI_OFS_STATUS     12'h004
`define CRI_OFS_VECTOR     12'h008

// control bits (write one to act)
`define CRI_CTRL_RAISE     0
`define CRI_CTRL_NMI       1
// status bits
`define CRI_STAT_PEND      0
`define CRI_STAT_INSERV    1
`define CRI_STAT_CHAIN     2

`endif

//--- common/cri_pkg.sv
/*
 * Types shared by the interrupt entry unit and its peripheral end.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cri_pkg;

    // maskable dispatch mode; 2'b11 is illegal
    typedef enum logic [1:0] {
        CRI_MODE_ZERO = 2'b00,
        CRI_MODE_ONE  = 2'b01,
        CRI_MODE_TWO  = 2'b10
    } cri_mode_t;

    // entry sequencer states
    typedef enum logic [1:0] {
        CRI_ST_RUN    = 2'b00,
        CRI_ST_ACK    = 2'b01,
        CRI_ST_TBL_LO = 2'b10,
        CRI_ST_TBL_HI = 2'b11
    } cri_state_t;

endpackage

//--- common/cri_if.sv
/*
 * Link between the processor entry unit and one peripheral end.
 * The peripheral drives the vector byte with a low output enable;
 * an undriven bus reads as all ones.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cri_map.svh"

interface cri_if;
    logic       nmi_req_n;
    logic       int_req_n;
    logic       iack_n;
    logic       ret_mask_n;
    logic [7:0] vec_out;
    logic       vec_oe_n;
    wire  [7:0] data_bus;

    // bus level worked out from the enable
    assign data_bus = vec_oe_n ? `CRI_IDLE_BYTE : vec_out;

    modport core (
        input  nmi_req_n,
        input  int_req_n,
        input  data_bus,
        output iack_n,
        output ret_mask_n
    );

    modport periph (
        output nmi_req_n,
        output int_req_n,
        output vec_out,
        output vec_oe_n,
        input  iack_n,
        input  ret_mask_n
    );
endinterface

`default_nettype wire

//--- src/cri_fall_det.sv
/*
 * Falling edge detector on an active-low request level.
 * Input assumed synchronous to clock; pulse is combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module cri_fall_det (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic level_n,
    output logic      fell
);
    logic prev_reg;

    // idle level is high, so a request held low through reset counts as an edge
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            prev_reg <= 1'b1;
        else if (clk_en)
            prev_reg <= level_n;
    end

    assign fell = prev_reg & ~level_n;
endmodule

`default_nettype wire

//--- src/cri_core_end.sv
/*
 * Interrupt entry unit of an 8-bit core: latches, mode, pc.
 * Assumes strobes ride with instr_last; core stalls while busy.
 */
// Implementation choices: the register offsets and the APB interface to the registers.
// Contract
// RQ1: reset loads pc with zero
// RQ2: reset clears enable, selects mode zero
// RQ3: reset drives control outputs inactive high
// RQ4: reset clears refresh counter
// RQ5: other registers untouched by reset
// RQ6: non-maskable request always accepted
// RQ7: reset, mask-off, maskable accept clear both
// RQ8: enable instruction sets both latches
// RQ9: maskable held off one instruction after enable
// RQ10: non-maskable before maskable
// RQ11: falling edge sets pending, sampled last clock
// RQ12: maskable needs low request, enable, no bus_request_in
// RQ13: non-maskable accept: shadow gets primary, jump 66H
// RQ14: nonmask return copies shadow into primary
// RQ15: page/refresh loads copy shadow to parity
// RQ16: maskable accept clears latches, dispatches by mode
// RQ17: mode zero executes peripheral-supplied instruction
// RQ18: mode one restarts at 0038H
// RQ19: mode two pointer: page high, byte even
// RQ20: mode two reads low then high byte
// RQ21: only highest chained peripheral drives vector
// RQ22: mask return tells peripheral service ended
// RQ23: accepting any interrupt ends halt
// RQ24: vector byte fetched in acknowledge cycle
`timescale 1ns/1ps
`default_nettype none
`include "cri_map.svh"
module cri_core_end (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              clk_en,
    cri_if.core                    link,
    input  wire logic              instr_last,
    input  wire logic              fetch_strobe,
    input  wire logic              enable_instr,
    input  wire logic              mask_off_instr,
    input  wire logic              vector_mode_zero_sel,
    input  wire logic              vector_mode_one_sel,
    input  wire logic              vector_mode_two_sel,
    input  wire logic              return_from_nonmask,
    input  wire logic              return_from_mask,
    input  wire logic              load_acc_from_page,
    input  wire logic              load_acc_from_refresh,
    input  wire logic              halt_instr,
    input  wire logic              bus_request_in_n,
    input  wire logic              page_load,
    input  wire logic [7:0]        page_data,
    input  wire logic              pc_load,
    input  wire logic [15:0]       pc_value,
    input  wire logic [7:0]        mem_rd_data,
    input  wire logic              mem_rd_valid,
    output logic [15:0]            pc_reg,
    output logic [7:0]             refresh_reg,
    output logic [7:0]             page_reg,
    output logic                   parity_flag_reg,
    output logic                   enable_primary,
    output logic                   enable_shadow,
    output cri_pkg::cri_mode_t     vector_mode_reg,
    output logic                   halt_n_reg,
    output logic                   busy_reg,
    output logic                   push_n_reg,
    output logic [15:0]            stack_data_reg,
    output logic                   exec_n_reg,
    output logic [7:0]             exec_byte_reg,
    output logic                   mem_rd_n_reg,
    output logic [15:0]            mem_addr_reg
);
    import cri_pkg::*;
    localparam logic [1:0] IACK_CYC = 2'(`CRI_IACK_CYC);
    cri_state_t state_reg;
    logic [1:0] cnt_reg;
    logic [7:0] low_byte_reg;
    logic       nmi_pend_reg, ei_hold_reg, nmi_fell, step;
    logic       prim_mid, shad_mid, nmi_take, int_take;
    logic       prim_next, shad_next;
    // request edge; input is already in the clock domain
    cri_fall_det u_nmi_edge (.clock(clock), .reset(reset),
        .clk_en(clk_en), .level_n(link.nmi_req_n), .fell(nmi_fell));
    // instruction boundary, only while no entry sequence runs
    assign step = instr_last & (state_reg == CRI_ST_RUN);
    // instruction effect first, then acceptance on top of it
    always_comb
    begin
        {prim_mid, shad_mid} = {enable_primary, enable_shadow};
        if (step && enable_instr)
            {prim_mid, shad_mid} = 2'b11;           // [RQ8]
        else if (step && mask_off_instr)
            {prim_mid, shad_mid} = 2'b00;           // [RQ7]
        else if (step && return_from_nonmask)
            prim_mid = enable_shadow;               // [RQ14]
        // non-maskable wins and ignores the latches
        nmi_take = step & nmi_pend_reg;             // [RQ6] [RQ10] [RQ11]
        // enable instruction and its successor both hold off
        int_take = step & ~nmi_pend_reg & ~link.int_req_n & prim_mid
                 & bus_request_in_n                 // [RQ12]
                 & ~enable_instr & ~ei_hold_reg;    // [RQ9]
        {prim_next, shad_next} = {prim_mid, shad_mid};
        if (nmi_take)
            {prim_next, shad_next} = {1'b0, prim_mid}; // [RQ13]
        else if (int_take)
            {prim_next, shad_next} = 2'b00;         // [RQ7] [RQ16]
    end
    // enable latches
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            {enable_primary, enable_shadow} <= 2'b00; // [RQ2] [RQ7]
        else if (clk_en)
            {enable_primary, enable_shadow} <= {prim_next, shad_next};
    end
    // one-instruction hold after an enable instruction
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            ei_hold_reg <= 1'b0;
        else if (clk_en && step)
            ei_hold_reg <= enable_instr;            // [RQ9]
    end
    // pending latch: a fresh edge wins over the clear
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            nmi_pend_reg <= 1'b0;
        else if (clk_en && nmi_fell)
            nmi_pend_reg <= 1'b1;                   // [RQ11]
        else if (clk_en && nmi_take)
            nmi_pend_reg <= 1'b0;                   // [RQ13]
    end
    // dispatch mode, zero selection wins over one, one over two
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            vector_mode_reg <= CRI_MODE_ZERO;       // [RQ2]
        else if (clk_en && step && vector_mode_zero_sel)
            vector_mode_reg <= CRI_MODE_ZERO;       // [RQ16]
        else if (clk_en && step && vector_mode_one_sel)
            vector_mode_reg <= CRI_MODE_ONE;
        else if (clk_en && step && vector_mode_two_sel)
            vector_mode_reg <= CRI_MODE_TWO;
    end
    // halt indication, active low
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            halt_n_reg <= 1'b1;                     // [RQ3]
        else if (clk_en && (nmi_take || int_take))
            halt_n_reg <= 1'b1;                     // [RQ23]
        else if (clk_en && step && halt_instr)
            halt_n_reg <= 1'b0;
    end
    // refresh counter: bit 7 stays as software left it
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            refresh_reg <= `CRI_REFRESH_RESET;      // [RQ4]
        else if (clk_en && fetch_strobe)
            refresh_reg <= {refresh_reg[7], refresh_reg[6:0] + 7'h01};
    end
    // software-owned state keeps its value across reset
    always_ff @(posedge clock)
    begin
        if (clk_en && page_load)
            page_reg <= page_data;                  // [RQ5]
        if (clk_en && step
            && (load_acc_from_page || load_acc_from_refresh))
            parity_flag_reg <= enable_shadow;       // [RQ15]
        if (clk_en && (nmi_take || int_take))
            stack_data_reg <= pc_reg;               // [RQ13] [RQ16]
    end
    // program counter: entry vectors beat the core's own loads
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            pc_reg <= `CRI_PC_RESET;                // [RQ1]
        else if (clk_en && nmi_take)
            pc_reg <= `CRI_NMI_VECTOR;              // [RQ13]
        else if (clk_en && int_take && vector_mode_reg == CRI_MODE_ONE)
            pc_reg <= `CRI_MODE1_VECTOR;            // [RQ18]
        else if (clk_en && state_reg == CRI_ST_TBL_HI && mem_rd_valid)
            pc_reg <= {mem_rd_data, low_byte_reg};  // [RQ20]
        else if (clk_en && pc_load)
            pc_reg <= pc_value;
    end
    // return from maskable: one-cycle end-of-service strobe
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            link.ret_mask_n <= 1'b1;                // [RQ3]
        else if (clk_en)
            link.ret_mask_n <= ~(step & return_from_mask); // [RQ22]
    end
    // entry sequencer: acknowledge cycle and vector table reads
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_reg     <= CRI_ST_RUN;
            cnt_reg       <= 2'h0;
            busy_reg      <= 1'b0;
            link.iack_n   <= 1'b1;                  // [RQ3]
            {push_n_reg, exec_n_reg, mem_rd_n_reg} <= 3'b111;
            {exec_byte_reg, low_byte_reg} <= 16'h0000;
            mem_addr_reg  <= 16'h0000;
        end
        else if (clk_en)
        begin
            {push_n_reg, exec_n_reg, mem_rd_n_reg} <= 3'b111;
            unique case (state_reg)
                CRI_ST_RUN:
                begin
                    // mode zero: the supplied call does its own push
                    push_n_reg <= ~nmi_take
                        & (~int_take | vector_mode_reg == CRI_MODE_ZERO);
                    if (int_take && vector_mode_reg != CRI_MODE_ONE)
                    begin
                        state_reg   <= CRI_ST_ACK;
                        cnt_reg     <= IACK_CYC;
                        busy_reg    <= 1'b1;
                        link.iack_n <= 1'b0;        // [RQ24]
                    end
                end
                CRI_ST_ACK:
                begin
                    cnt_reg <= cnt_reg - 2'h1;
                    if (cnt_reg == 2'h1)
                    begin
                        link.iack_n <= 1'b1;
                        if (vector_mode_reg == CRI_MODE_TWO)
                        begin
                            mem_addr_reg <= {page_reg,
                                link.data_bus[7:1], 1'b0}; // [RQ19]
                            mem_rd_n_reg <= 1'b0;
                            state_reg    <= CRI_ST_TBL_LO;
                        end
                        else
                        begin
                            exec_byte_reg <= link.data_bus; // [RQ17]
                            exec_n_reg    <= 1'b0;
                            busy_reg      <= 1'b0;
                            state_reg     <= CRI_ST_RUN;
                        end
                    end
                end
                CRI_ST_TBL_LO:
                begin
                    if (mem_rd_valid)
                    begin
                        low_byte_reg <= mem_rd_data; // [RQ20]
                        mem_addr_reg <= {mem_addr_reg[15:1], 1'b1};
                        mem_rd_n_reg <= 1'b0;
                        state_reg    <= CRI_ST_TBL_HI;
                    end
                end
                CRI_ST_TBL_HI:
                begin
                    if (mem_rd_valid)
                    begin
                        busy_reg  <= 1'b0;
                        state_reg <= CRI_ST_RUN;
                    end
                end
            endcase
        end
    end
endmodule

`default_nettype wire

//--- src/cri_periph_end.sv
/*
 * Peripheral end: raises maskable and non-maskable requests, takes
 * part in a priority chain and supplies its vector byte during the
 * acknowledge cycle. Software reaches it over APB.
 * Assumes chain_in is high when no higher device claims the chain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cri_map.svh"

module cri_periph_end (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        clk_en,
    cri_if.periph            link,
    input  wire logic        chain_in,
    output logic             chain_out_reg,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import cri_pkg::*;

    logic       pend_reg;
    logic       inserv_reg;
    logic [7:0] vector_reg;
    logic       take;
    logic       wr_ctrl;
    logic       grant;

    // access taken one cycle into the access phase
    assign take    = psel & penable & ~pready;
    assign wr_ctrl = take & pwrite & (paddr == `CRI_OFS_CTRL);
    // vector only from the first claimant in the chain
    assign grant   = ~link.iack_n & pend_reg & chain_in & link.vec_oe_n;

    // apb slave, one wait state, error on unmapped offsets
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else if (clk_en)
        begin
            pready  <= take;
            pslverr <= 1'b0;
            if (take)
            begin
                prdata <= 32'h00000000;
                unique case (paddr)
                    `CRI_OFS_CTRL:
                        prdata <= 32'h00000000;
                    `CRI_OFS_STATUS:
                        prdata <= {29'h00000000, chain_out_reg,
                                   inserv_reg, pend_reg};
                    `CRI_OFS_VECTOR:
                        prdata <= {24'h000000, vector_reg};
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // vector byte register
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            vector_reg <= 8'h00;
        else if (clk_en && take && pwrite
                 && paddr == `CRI_OFS_VECTOR)
            vector_reg <= pwdata[7:0];
    end

    // request and service state; a new raise beats the grant
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pend_reg   <= 1'b0;
            inserv_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_ctrl && pwdata[`CRI_CTRL_RAISE])
                pend_reg <= 1'b1;
            else if (grant)
                pend_reg <= 1'b0;
            if (grant)
                inserv_reg <= 1'b1;
            else if (!link.ret_mask_n)
                inserv_reg <= 1'b0;                 // [RQ22]
        end
    end

    // link outputs and chain onward
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            link.int_req_n <= 1'b1;
            link.nmi_req_n <= 1'b1;
            link.vec_oe_n  <= 1'b1;
            link.vec_out   <= 8'h00;
            chain_out_reg  <= 1'b1;
        end
        else if (clk_en)
        begin
            link.int_req_n <= ~pend_reg;
            // one-cycle low gives the falling edge the core latches
            link.nmi_req_n <= ~(wr_ctrl & pwdata[`CRI_CTRL_NMI]);
            if (grant)
            begin
                link.vec_oe_n <= 1'b0;              // [RQ21] [RQ24]
                link.vec_out  <= vector_reg;        // [RQ17] [RQ19]
            end
            else if (link.iack_n)
                link.vec_oe_n <= 1'b1;
            chain_out_reg  <= chain_in & ~pend_reg & ~inserv_reg; // [RQ21]
        end
    end
endmodule

`default_nettype wire

//--- test/cri_asserts.sv
/*
 * Link checker: watches the signals between the two ends.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module cri_asserts (
    input wire logic clock,
    input wire logic reset,
    input wire logic int_req_n,
    input wire logic iack_n,
    input wire logic ret_mask_n,
    input wire logic vec_oe_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // link idle right after release
    a_reset_idle: assert property (
        $fell(reset) |-> iack_n && ret_mask_n && vec_oe_n)
        else $error("link not idle after reset");
    // acknowledge lasts exactly two cycles
    a_iack_two: assert property (
        $fell(iack_n) |=> !iack_n ##1 iack_n)
        else $error("acknowledge length wrong");
    a_iack_cause: assert property (
        $fell(iack_n) |-> !$past(int_req_n))
        else $error("acknowledge without request");
    // vector must sit on the bus before the core samples it
    a_vec_early: assert property (
        $fell(iack_n) |=> !vec_oe_n)
        else $error("vector late in acknowledge");
    a_vec_in_ack: assert property (
        $fell(vec_oe_n) |-> !iack_n)
        else $error("vector driven outside acknowledge");
    a_vec_release: assert property (
        !vec_oe_n && iack_n |=> vec_oe_n)
        else $error("vector held after acknowledge");
    a_req_drop: assert property (
        $fell(vec_oe_n) |-> ##[0:1] int_req_n)
        else $error("request kept after grant");
    a_ret_pulse: assert property (
        $fell(ret_mask_n) |=> ret_mask_n)
        else $error("end of service not one cycle");

    c_ack: cover property ($fell(iack_n));
    c_vec: cover property ($fell(vec_oe_n));
    c_ret: cover property ($fell(ret_mask_n));
endmodule

`default_nettype wire

//--- test/tb_cpu_reset_and_interrupt_entry.sv
/*
 * Self-checking bench: core end and peripheral end on one link,
 * strobes and APB driven here. Assumes the hand-over timing.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cri_map.svh"

module tb_cpu_reset_and_interrupt_entry;
    import cri_pkg::*;
    localparam logic [9:0] OP_EN = 10'h200, OP_OFF = 10'h100;
    localparam logic [9:0] OP_Z = 10'h080, OP_ONE = 10'h040;
    localparam logic [9:0] OP_TWO = 10'h020, OP_RN = 10'h010;
    localparam logic [9:0] OP_RM = 10'h008, OP_LP = 10'h004;
    localparam logic [9:0] OP_HLT = 10'h001;
    logic clock = '0, reset = '1, instr_last = '0, pc_load = '0;
    logic bus_request_in_n = '1, page_load = '0, mem_rd_valid = '0;
    logic psel = '0, penable = '0, pwrite = '0, err;
    logic [9:0] op = '0;
    logic [7:0] page_data = '0, mem_rd_data = '0, vb;
    logic [15:0] pc_value = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, rd, lf = 32'hFB260E93, prdata;
    logic pready, pslverr, parity_flag_reg, enable_primary, busy_reg;
    logic enable_shadow, halt_n_reg, push_n_reg, exec_n_reg;
    logic mem_rd_n_reg;
    logic [15:0] pc_reg, stack_data_reg, mem_addr_reg;
    logic [7:0] refresh_reg, page_reg, exec_byte_reg;
    cri_mode_t vector_mode_reg;
    int bad_count = 0, samples_checked = 0, p = 0, s = 0;

    // the two ends face each other; refresh fetches left idle
    cri_if lk ();
    cri_core_end cri_core_end_i (.*, .link(lk), .clk_en(1'h1),
        .fetch_strobe(1'h0), .enable_instr(op[9]),
        .mask_off_instr(op[8]), .vector_mode_zero_sel(op[7]),
        .vector_mode_one_sel(op[6]), .vector_mode_two_sel(op[5]),
        .return_from_nonmask(op[4]), .return_from_mask(op[3]),
        .load_acc_from_page(op[2]), .load_acc_from_refresh(op[1]),
        .halt_instr(op[0]));
    cri_periph_end cri_periph_end_i (.*, .link(lk), .clk_en(1'h1),
        .chain_in(1'h1), .chain_out_reg());
    cri_asserts cri_asserts_i (.clock, .reset,
        .int_req_n(lk.int_req_n), .iack_n(lk.iack_n),
        .ret_mask_n(lk.ret_mask_n), .vec_oe_n(lk.vec_oe_n));

    // 125 MHz
    always #4 clock = ~clock;

    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic complete_run();
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask

    // latches against the bench model
    task automatic lat();
        chk("latches", {p[0], s[0]}, {enable_primary, enable_shadow});
    endtask

    // a spent bound ends the run
    task automatic lim(input int i);
        if (i >= 50)
        begin
            bad_count++;
            complete_run();
        end
    endtask

    // one instruction: strobes ride with instr_last for one edge
    task automatic ins(input logic [9:0] o);
        @(posedge clock);
        op <= o;
        instr_last <= '1;
        @(posedge clock);
        op <= '0;
        instr_last <= '0;
        #1;
    endtask

    // waits for a level, checked one step after each edge
    task automatic wt(ref logic g, input logic v);
        int i;
        i = 0;
        #1;
        while (g !== v && i < 50)
        begin
            @(posedge clock);
            #1;
            i++;
        end
        lim(i);
    endtask

    // table read answer; data line scrambled once released
    task automatic mem(input logic [7:0] b);
        @(posedge clock);
        mem_rd_valid <= '1;
        mem_rd_data <= b;
        @(posedge clock);
        mem_rd_valid <= '0;
        mem_rd_data <= ~b;
    endtask

    // APB: setup, access held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clock);
        psel <= '1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= '1;
        do
        begin
            @(posedge clock);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        rd = prdata;
        err = pslverr;
        psel <= '0;
        penable <= '0;
        lim(i);
    endtask

    initial
    begin
        repeat (10) @(posedge clock);
        reset <= '0;
        @(posedge clock);
        #1;
        chk("pc", `CRI_PC_RESET, pc_reg);
        lat();
        chk("mode", CRI_MODE_ZERO, vector_mode_reg);
        chk("halt", 1, halt_n_reg);
        chk("refresh", `CRI_REFRESH_RESET, refresh_reg);
        $display("reset test done");
        // nonmaskable entry out of halt, shadow round trip
        lf = nx(lf);
        pc_load <= '1;
        pc_value <= lf[15:0];
        @(posedge clock);
        pc_load <= '0;
        ins(OP_EN);
        p = 1;
        s = 1;
        lat();
        ins(OP_HLT);
        chk("halt", 0, halt_n_reg);
        apb(1, `CRI_OFS_CTRL, 32'h2);
        repeat (3) @(posedge clock);
        ins('0);
        p = 0;
        chk("pc", `CRI_NMI_VECTOR, pc_reg);
        chk("stack", lf[15:0], stack_data_reg);
        chk("push", 0, push_n_reg);
        lat();
        chk("halt", 1, halt_n_reg);
        ins(OP_LP);
        chk("parity", s, parity_flag_reg);
        ins(OP_RN);
        p = s;
        lat();
        ins(OP_OFF);
        p = 0;
        s = 0;
        lat();
        $display("nonmaskable test done");
        // mode one: hold-off, bus request, priority
        ins(OP_ONE);
        chk("mode", CRI_MODE_ONE, vector_mode_reg);
        apb(1, `CRI_OFS_CTRL, 32'h1);
        ins(OP_EN);
        ins('0);
        p = 1;
        s = 1;
        lat();
        bus_request_in_n <= '0;
        ins('0);
        bus_request_in_n <= '1;
        lat();
        apb(1, `CRI_OFS_CTRL, 32'h2);
        repeat (3) @(posedge clock);
        ins('0);
        p = 0;
        chk("pc", `CRI_NMI_VECTOR, pc_reg);
        lat();
        ins(OP_RN);
        s = 0;
        chk("pc", `CRI_MODE1_VECTOR, pc_reg);
        lat();
        // mode two: table pointer and two reads
        lf = nx(lf);
        vb = lf[7:0] | 8'h01;
        page_load <= '1;
        page_data <= lf[15:8];
        @(posedge clock);
        page_load <= '0;
        apb(1, `CRI_OFS_VECTOR, {24'h0, vb});
        ins(OP_TWO);
        chk("mode", CRI_MODE_TWO, vector_mode_reg);
        ins(OP_EN);
        ins('0);
        ins('0);
        wt(mem_rd_n_reg, 1'b0);
        chk("addr", {lf[15:8], vb[7:1], 1'b0}, mem_addr_reg);
        mem(lf[23:16]);
        wt(mem_rd_n_reg, 1'b0);
        chk("addr", {lf[15:8], vb[7:1], 1'b1}, mem_addr_reg);
        mem(lf[31:24]);
        wt(busy_reg, 1'b0);
        chk("pc", lf[31:16], pc_reg);
        apb(0, `CRI_OFS_STATUS, '0);
        chk("inserv", 1, rd[`CRI_STAT_INSERV]);
        ins(OP_RM);
        chk("ret", 0, lk.ret_mask_n);
        apb(0, `CRI_OFS_STATUS, '0);
        chk("inserv", 0, rd[`CRI_STAT_INSERV]);
        $display("mode two test done");
        // mode zero: supplied instruction byte
        apb(1, `CRI_OFS_VECTOR, {24'h0, lf[7:0]});
        apb(1, `CRI_OFS_CTRL, 32'h1);
        ins(OP_Z);
        ins(OP_EN);
        ins('0);
        ins('0);
        wt(exec_n_reg, 1'b0);
        chk("exec", lf[7:0], exec_byte_reg);
        p = 0;
        s = 0;
        lat();
        apb(1, 12'hFFC, '0);
        chk("slverr", 1, err);
        $display("mode zero test done");
        complete_run();
    end
endmodule

`default_nettype wire
